/* File: rtl/psc_pkg.sv */
// Constants, address layout and carrier types of the port statistics counters.
// Assumes a single 10 MHz core clock and a word-aligned register port.
package psc_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int NUM_PORTS = 4;          // Ingress ports served.
   localparam int PORT_W    = 2;          // Bits of a port number.
   localparam int NUM_CNT   = 8;          // Counters per port.
   localparam int IDX_W     = 3;          // Bits of a counter index.
   localparam int CNT_W     = 40;         // Full counter width.
   localparam int LOW_W     = 32;         // Low word width.
   localparam int HIGH_W    = 8;          // High byte width.
   localparam int EVT_W     = 12;         // Event vector width.
   localparam int PRIO_W    = 3;          // Frame priority width.
   localparam int BYTES_W   = 16;         // Frame length width.
   localparam int ADDR_W    = 12;         // Register address width.
   localparam int DATA_W    = 32;         // Register data width.

   // ----------------------------------------------------------------------
   // Address regions and reset values
   // ----------------------------------------------------------------------
   localparam logic [3:0] RGN_EVT_MASK = 4'h0;   // Global event masks, 8 bytes apart.
   localparam logic [3:0] RGN_INIT     = 4'h1;   // Initialisation control.
   localparam logic [3:0] RGN_CFG      = 4'h2;   // Per-port, per-counter setup.
   localparam logic [3:0] RGN_COUNT    = 4'h3;   // Counter low word and high byte.
   localparam logic [3:0] RGN_FLAGS    = 4'h4;   // Per-port event flags.
   localparam logic       HALF_LOW     = 1'h0;   // Selects the low word.
   localparam logic       HALF_HIGH    = 1'h1;   // Selects the high byte.
   localparam int         INIT_BIT     = 0;      // Start bit of the init control.
   localparam logic [CNT_W-1:0]  CNT_RST  = 40'h00_0000_0000;
   localparam logic [EVT_W-1:0]  EVT_RST  = 12'h000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Frame class selector codes
   // ----------------------------------------------------------------------
   localparam logic [3:0] FC_CLEAN_NOMATCH = 4'h0;
   localparam logic [3:0] FC_CLEAN_MATCH   = 4'h1;
   localparam logic [3:0] FC_ERROR_MATCH   = 4'h2;
   localparam logic [3:0] FC_MATCH_ANY     = 4'h3;
   localparam logic [3:0] FC_ERROR_NOMATCH = 4'h4;
   localparam logic [3:0] FC_ERROR_ANY     = 4'h5;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   // Register address fields; one layout serves every region.
   typedef struct packed {
      logic [3:0]        region;
      logic [PORT_W-1:0] port;
      logic [IDX_W-1:0]  idx;
      logic              half;
      logic [1:0]        byte_off;
   } psc_addr_type;

   // Per-counter setup as it reads back in the low bits of the word.
   typedef struct packed {
      logic              byte_mode_bit;
      logic [3:0]        frame_class_selector;
      logic [7:0]        prio_mask;
   } psc_cfg_type;

   // One frame from the analyzer pipeline, valid for one cycle.
   typedef struct packed {
      logic               valid;
      logic [PORT_W-1:0]  port;
      logic [PRIO_W-1:0]  prio;
      logic               error;
      logic               no_dest;
      logic [EVT_W-1:0]   events;
      logic [BYTES_W-1:0] bytes;
   } psc_frame_type;

endpackage : psc_pkg

/* File: rtl/psc_counters.sv */
// Per-port statistics counters with register port and frame input.
// Assumes frames come from logic on core_clk, one frame per cycle at most.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module psc_counters
   import psc_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output      logic [DATA_W-1:0]   reg_rdata,
   input  wire psc_frame_type       frame_in
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [EVT_W-1:0]  gmask_q [NUM_CNT];                   // Global event masks.
   psc_cfg_type       cfg_q   [NUM_PORTS][NUM_CNT];        // Counter setup.
   logic [CNT_W-1:0]  cnt_q   [NUM_PORTS][NUM_CNT];        // Counter values.
   logic [CNT_W-1:0]  cnt_d   [NUM_PORTS][NUM_CNT];        // Next counter values.
   logic [EVT_W-1:0]  flags_q [NUM_PORTS];                 // Sticky event flags.
   logic [EVT_W-1:0]  flags_d [NUM_PORTS];                 // Next sticky event flags.
   logic [HIGH_W-1:0] shadow_q;                            // Latched high byte.
   logic [DATA_W-1:0] rdata_q;                             // Read answer.
   psc_addr_type      a;                                   // Decoded address.
   logic              init_pulse;                          // Init control write.
   logic [NUM_CNT-1:0] hit;                                // Counter qualifies.
   logic [CNT_W-1:0]  inc [NUM_CNT];                       // Amount to add.

   assign a          = psc_addr_type'(reg_addr);
   assign init_pulse = reg_wr && a.region == RGN_INIT && reg_wdata[INIT_BIT];
   assign reg_rdata  = rdata_q;

   // ----------------------------------------------------------------------
   // Qualification per counter index
   // ----------------------------------------------------------------------
   // Each index looks at the setup of the frame's own port only.
   for (genvar i = 0; i < NUM_CNT; i++) begin : g_qual
      psc_cfg_type c;
      logic        prio_ok;
      logic        match;
      logic        err;
      logic        cls_ok;                                          // Selector accepts the frame.
      assign c       = cfg_q[frame_in.port][i];
      assign prio_ok = c.prio_mask[frame_in.prio];
      assign match   = |(gmask_q[i] & frame_in.events);
      // A frame with no destination is seen as aborted, hence errored.
      assign err     = frame_in.error || frame_in.no_dest;
      assign inc[i]  = c.byte_mode_bit ? CNT_W'(frame_in.bytes)
                                       : CNT_W'(1);
      // Decodes the selector against the error and match state of the frame.
      always_comb
      begin
         // Codes above the defined six never count.
         unique case (c.frame_class_selector)
            FC_CLEAN_NOMATCH: cls_ok = !err && !match;
            FC_CLEAN_MATCH:   cls_ok = !err && match;
            FC_ERROR_MATCH:   cls_ok = err && match;
            FC_MATCH_ANY:     cls_ok = match;
            FC_ERROR_NOMATCH: cls_ok = err && !match;
            FC_ERROR_ANY:     cls_ok = err;
            default:          cls_ok = 1'b0;
         endcase
      end
      // Priority and valid gate last, so an idle cycle never counts, whatever
      // the idle fields of the frame carrier happen to hold.
      assign hit[i] = cls_ok && prio_ok && frame_in.valid;
   end

   // ----------------------------------------------------------------------
   // Counter next values
   // ----------------------------------------------------------------------
   // A software preset of a counter wins over a frame in the same cycle;
   // init clears first and a frame in that cycle is still counted.
   always_comb
   begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         for (int i = 0; i < NUM_CNT; i++)
         begin
            cnt_d[p][i] = init_pulse ? CNT_RST : cnt_q[p][i];
            if (reg_wr && a.region == RGN_COUNT && a.port == PORT_W'(p) && a.idx == IDX_W'(i))
            begin
               if (a.half == HALF_LOW)
                  cnt_d[p][i][LOW_W-1:0] = reg_wdata;
               else
                  cnt_d[p][i][CNT_W-1:LOW_W] = reg_wdata[HIGH_W-1:0];
            end
            else if (hit[i] && frame_in.port == PORT_W'(p))
            begin
               // The sum is cut to 40 bits, so the counter wraps silently.
               cnt_d[p][i] = cnt_d[p][i] + inc[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Counter registers
   // ----------------------------------------------------------------------
   // All counters load their next values at once; the array is wide, but a
   // single register stage keeps a read coherent with the frame just counted.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
            for (int i = 0; i < NUM_CNT; i++)
               cnt_q[p][i] <= CNT_RST;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   // Setup survives init; only counts and flags are cleared by it.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < NUM_CNT; i++)
         begin
            gmask_q[i] <= EVT_RST;
            for (int p = 0; p < NUM_PORTS; p++)
               cfg_q[p][i] <= '0;
         end
      end
      else if (reg_wr)
      begin
         if (a.region == RGN_EVT_MASK)
            gmask_q[a.idx] <= reg_wdata[EVT_W-1:0];
         else if (a.region == RGN_CFG)
            cfg_q[a.port][a.idx] <= psc_cfg_type'(reg_wdata[$bits(psc_cfg_type)-1:0]);
      end
   end

   // ----------------------------------------------------------------------
   // Sticky event flags
   // ----------------------------------------------------------------------
   // Next flag values. Writing one clears a flag, but an event in the same
   // cycle sets it again, so software never loses an event it has not seen.
   always_comb
   begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         flags_d[p] = flags_q[p];
         if (init_pulse)
         begin
            // Init wipes the flags of every port at once.
            flags_d[p] = EVT_RST;
         end
         else if (reg_wr && a.region == RGN_FLAGS && a.port == PORT_W'(p))
         begin
            // Write one to clear, on the addressed port only.
            flags_d[p] = flags_q[p] & ~reg_wdata[EVT_W-1:0];
         end
         if (frame_in.valid && frame_in.port == PORT_W'(p))
         begin
            // The raw event vector is recorded; the set wins over a clear.
            flags_d[p] = flags_d[p] | frame_in.events;
         end
      end
   end

   // Flag registers, all clear after reset.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
            flags_q[p] <= EVT_RST;
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   // ----------------------------------------------------------------------
   // Read port and shadow latch
   // ----------------------------------------------------------------------
   // The high read returns the shadow, whatever counter it addresses, so
   // software must pair it with the low read just before.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         shadow_q <= '0;
         rdata_q  <= DATA_ZERO;
      end
      else
      begin
         rdata_q <= DATA_ZERO;
         if (reg_rd)
         begin
            unique case (a.region)
               RGN_EVT_MASK: rdata_q <= DATA_W'(gmask_q[a.idx]);
               RGN_CFG:      rdata_q <= DATA_W'(cfg_q[a.port][a.idx]);
               RGN_FLAGS:    rdata_q <= DATA_W'(flags_q[a.port]);
               RGN_COUNT:
               begin
                  if (a.half == HALF_LOW)
                  begin
                     rdata_q  <= cnt_q[a.port][a.idx][LOW_W-1:0];
                     shadow_q <= cnt_q[a.port][a.idx][CNT_W-1:LOW_W];
                  end
                  else
                     rdata_q <= DATA_W'(shadow_q);
               end
               default:      rdata_q <= DATA_ZERO;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // A software write to any counter word overrides the frame update, so the
   // checks on the counting path leave those cycles out.
   logic sw_cnt_wr;   // Software writes some counter word this cycle.
   assign sw_cnt_wr = reg_wr && a.region == RGN_COUNT;

   // The fixed indices below are those a normal setup drives: index 0 for the
   // class decode, index 5 of port 2 for byte mode and priority, index 7 of
   // port 3 for the wrap. A check on an index nobody configures proves nothing.
   AST_INIT_CLEARS: assert property (init_pulse && !frame_in.valid
      |=> cnt_q[1][0] == CNT_RST && flags_q[1] == EVT_RST)
      else $error("Init did not clear counter and flags.");
   AST_CLASS_ERROR: assert property (cfg_q[frame_in.port][0].frame_class_selector == FC_CLEAN_NOMATCH
      && (frame_in.error || frame_in.no_dest) |-> !hit[0])
      else $error("Errored frame counted as clean.");
   AST_NODEST_ERR: assert property (frame_in.valid && frame_in.no_dest
      && cfg_q[frame_in.port][0].prio_mask[frame_in.prio]
      && cfg_q[frame_in.port][0].frame_class_selector == FC_ERROR_ANY |-> hit[0])
      else $error("Frame without destination not seen as errored.");
   AST_PRIO_GATE: assert property (!cfg_q[frame_in.port][5].prio_mask[frame_in.prio] |-> !hit[5])
      else $error("Masked priority counted.");
   AST_EVT_MATCH: assert property (cfg_q[frame_in.port][0].frame_class_selector == FC_MATCH_ANY
      && (gmask_q[0] & frame_in.events) == EVT_RST |-> !hit[0])
      else $error("Counted without event match.");
   AST_BYTE_ADD: assert property (hit[5] && frame_in.port == 2'h2 && cfg_q[2][5].byte_mode_bit
      && !init_pulse && !sw_cnt_wr
      |=> cnt_q[2][5] == $past(cnt_q[2][5]) + CNT_W'($past(frame_in.bytes)))
      else $error("Byte mode did not add frame length.");
   AST_SHADOW: assert property (reg_rd && a.region == RGN_COUNT && a.half == HALF_LOW
      |=> shadow_q == $past(cnt_q[a.port][a.idx][CNT_W-1:LOW_W]))
      else $error("High byte not latched on low read.");
   AST_LOW_READ: assert property (reg_rd && a.region == RGN_COUNT && a.half == HALF_LOW
      |=> rdata_q == $past(cnt_q[a.port][a.idx][LOW_W-1:0]))
      else $error("Low word read does not match the counter.");
   AST_PRESET_LOW: assert property (reg_wr && a.region == RGN_COUNT && a.half == HALF_LOW
      |=> cnt_q[$past(a.port)][$past(a.idx)][LOW_W-1:0] == $past(reg_wdata))
      else $error("Low word preset did not land.");
   AST_STICKY: assert property (frame_in.valid
      |=> (flags_q[$past(frame_in.port)] & $past(frame_in.events)) == $past(frame_in.events))
      else $error("Event flag not set.");
   AST_FLAG_W1C: assert property (reg_wr && a.region == RGN_FLAGS && !frame_in.valid
      |=> (flags_q[$past(a.port)] & $past(reg_wdata[EVT_W-1:0])) == EVT_RST)
      else $error("Event flag not cleared by a one.");
   AST_WRAP: assert property (hit[7] && frame_in.port == 2'h3 && !cfg_q[3][7].byte_mode_bit
      && !init_pulse && !sw_cnt_wr && cnt_q[3][7] == ~CNT_RST |=> cnt_q[3][7] == CNT_RST)
      else $error("Counter did not wrap to zero.");
   AST_HIGH_NARROW: assert property (reg_rd && a.region == RGN_COUNT && a.half == HALF_HIGH
      |=> rdata_q[DATA_W-1:HIGH_W] == '0 ##1 rdata_q == DATA_ZERO || $past(reg_rd))
      else $error("High byte read wider than eight bits.");

   COV_BYTE_COUNT: cover property (hit[5] && cfg_q[frame_in.port][5].byte_mode_bit);
   COV_LOW_HIGH:   cover property (reg_rd && a.region == RGN_COUNT && a.half == HALF_LOW
                                   ##1 reg_rd && a.region == RGN_COUNT && a.half == HALF_HIGH);
   COV_INIT:       cover property (init_pulse ##2 frame_in.valid);
   COV_WRAP:       cover property (hit[7] && frame_in.port == 2'h3 && cnt_q[3][7] == ~CNT_RST);
   COV_FLAG_CLEAR: cover property (reg_wr && a.region == RGN_FLAGS ##1 flags_q[2] != EVT_RST);

endmodule : psc_counters

/* File: tb/psc_frame_src.sv */
// Model of the analyzer pipeline that hands frames to the counters.
// Assumes the bench posts frames right after a rising edge of core_clk.
`timescale 1ns/1ps
module psc_frame_src
   import psc_pkg::*;
(
   input  wire logic    core_clk,
   input  wire logic    reset_n,
   output psc_frame_type frame_in
);
   // ---------------------------------------------------------------
   // Frame queue and driver
   // ---------------------------------------------------------------
   psc_frame_type fq[$];   // Frames waiting to be driven.
   int            seed;    // Seed of the idle pattern.

   // Queues one frame; it is driven in the next clock cycle.
   task automatic post(input psc_frame_type f);
      fq.push_back(f);
   endtask : post

   initial
   begin
      seed = 51722;
      frame_in = '0;
   end

   // Drives just after each edge; idle cycles carry a changing pattern, so
   // a design that looks at fields without valid is caught.
   always @(posedge core_clk)
   begin
      #1;
      if (reset_n && fq.size() != 0)
         frame_in <= fq.pop_front();
      else
         frame_in <= psc_frame_type'({1'b0, 35'({$random(seed), $random(seed)})});
   end
endmodule : psc_frame_src

/* File: tb/tb.sv */
// Self-checking bench of the port statistics counters.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
module tb
   import psc_pkg::*;
;
   logic              core_clk;    // 10 MHz clock.
   logic              reset_n;     // Active low reset.
   logic [ADDR_W-1:0] reg_addr;    // Register address.
   logic [DATA_W-1:0] reg_wdata;   // Write data.
   logic [DATA_W-1:0] reg_rdata;   // Read data.
   logic              reg_wr;      // Write strobe.
   logic              reg_rd;      // Read strobe.
   psc_frame_type     frame_in;    // Frames from the partner.
   logic [DATA_W-1:0] exp_q[$];    // Expected read data, oldest first.
   logic              rd_seen;     // A read was strobed last cycle.
   logic [39:0]       tot;         // Expected counter value.
   logic [EVT_W-1:0]  ev;          // Event vector of a frame.
   logic [EVT_W-1:0]  fl;          // Expected event flags.
   logic              er;          // Frame error.
   logic              m;           // Frame should match the mask.
   int                errors;
   int                n_tests;
   int                seed;

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   psc_counters u_psc_counters (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_in(frame_in));
   psc_frame_src u_psc_frame_src (.core_clk(core_clk), .reset_n(reset_n), .frame_in(frame_in));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] ad(input logic [3:0] r, input int p, input int i, input logic h);
      psc_addr_type a;
      a = '{r, p[PORT_W-1:0], i[IDX_W-1:0], h, 2'h0};
      return a;
   endfunction : ad

   // Whether a frame counts for a selector code.
   function automatic logic hit(input int c, input logic e, input logic mt);
      case (c)
         0: return !e && !mt;
         1: return !e && mt;
         2: return e && mt;
         3: return mt;
         4: return e && !mt;
         5: return e;
         default: return 1'b0;
      endcase
   endfunction : hit

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd

   // Low word then high byte back to back; optionally a frame lands with the high read.
   task automatic rdc(input int p, input int i, input logic [39:0] e, input logic fr);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= ad(RGN_COUNT, p, i, HALF_LOW);
      exp_q.push_back(e[31:0]);
      @(posedge core_clk);
      reg_addr <= ad(RGN_COUNT, p, i, HALF_HIGH);
      exp_q.push_back({24'h0, e[39:32]});
      if (fr)
         u_psc_frame_src.post('{1'b1, p[1:0], 3'h0, 1'b0, 1'b0, 12'hFFF, 16'h0001});
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rdc

   task automatic wrc(input int p, input int i, input logic [39:0] v);
      wr(ad(RGN_COUNT, p, i, HALF_LOW), v[31:0]);
      wr(ad(RGN_COUNT, p, i, HALF_HIGH), {24'h0, v[39:32]});
   endtask : wrc

   task automatic frm(input int p, input logic [2:0] pr, input logic e, input logic nd,
                      input logic [EVT_W-1:0] v, input logic [15:0] by);
      @(posedge core_clk);
      u_psc_frame_src.post('{1'b1, p[1:0], pr, e, nd, v, by});
      @(posedge core_clk);
   endtask : frm

   task automatic give_verdict;
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // Takes the oldest note whenever read data stand and compares.
   always @(negedge core_clk)
   begin
      if (rd_seen)
      begin
         n_tests++;
         if (exp_q.size() == 0 || reg_rdata !== exp_q[0])
         begin
            errors++;
            $display("[ERR] %0t read data %h unexpected", $time, reg_rdata);
         end
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
      rd_seen = reg_rd;
   end

   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge core_clk);
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      give_verdict();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      seed = 51722;
      errors = 0;
      n_tests = 0;
      rd_seen = 1'b0;
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      // Reset values, init control and an unmapped place read zero.
      rd(ad(RGN_CFG, 0, 3, 0), DATA_ZERO);
      rd(ad(RGN_EVT_MASK, 0, 3, 0), DATA_ZERO);
      rd(ad(RGN_INIT, 0, 0, 0), DATA_ZERO);
      rd(ad(RGN_FLAGS, 1, 0, 0), DATA_ZERO);
      rd(12'h500, DATA_ZERO);
      // Selector codes 0 to 6 against every error and match case.
      wr(ad(RGN_EVT_MASK, 0, 0, 0), 32'h0000_00F0);
      for (int c = 0; c < 7; c++)
      begin
         wr(ad(RGN_CFG, 1, 0, 0), {19'h0, 1'b0, 4'(c), 8'hFF});
         wr(ad(RGN_INIT, 0, 0, 0), 32'h0000_0001);
         tot = '0;
         for (int k = 0; k < 5; k++)
         begin
            er = k[0] && k < 4;
            m = k[1] || k == 4;
            ev = EVT_W'($random(seed));
            ev[7:4] = m ? (ev[7:4] | 4'h2) : 4'h0;
            frm(1, 3'($random(seed)), er, k == 4, ev, 16'($random(seed)));
            tot = tot + 40'(hit(c, er || k == 4, m));
         end
         rdc(1, 0, tot, 1'b0);
      end
      wr(ad(RGN_INIT, 0, 0, 0), 32'h0000_0001);
      rd(ad(RGN_FLAGS, 1, 0, 0), DATA_ZERO);
      rdc(1, 0, 40'h0, 1'b0);
      // Byte mode with a priority mask; flags collect events and clear on one.
      wr(ad(RGN_EVT_MASK, 0, 5, 0), 32'h0000_0800);
      wr(ad(RGN_CFG, 2, 5, 0), {19'h0, 1'b1, 4'h3, 8'h24});
      tot = '0;
      fl = '0;
      for (int pr = 0; pr < 8; pr++)
      begin
         ev = EVT_W'($random(seed)) | 12'h800;
         reg_wdata <= $random(seed);
         @(posedge core_clk);
         frm(2, 3'(pr), reg_wdata[16], 1'b0, ev, reg_wdata[15:0]);
         if (pr == 2 || pr == 5)
            tot = tot + 40'(reg_wdata[15:0]);
         fl = fl | ev;
      end
      rdc(2, 5, tot, 1'b0);
      rd(ad(RGN_FLAGS, 2, 0, 0), {20'h0, fl});
      wr(ad(RGN_FLAGS, 2, 0, 0), {20'h0, fl & 12'h0FF});
      rd(ad(RGN_FLAGS, 2, 0, 0), {20'h0, fl & 12'hF00});
      // Wrap of a full counter and the coherent high byte.
      wr(ad(RGN_EVT_MASK, 0, 7, 0), 32'h0000_0001);
      wr(ad(RGN_CFG, 3, 7, 0), {19'h0, 1'b0, 4'h1, 8'hFF});
      wrc(3, 7, 40'hFF_FFFF_FFFF);
      frm(3, 3'h0, 1'b0, 1'b0, 12'h001, 16'h0040);
      rdc(3, 7, 40'h00_0000_0000, 1'b0);
      wrc(3, 7, 40'h00_FFFF_FFFF);
      rdc(3, 7, 40'h00_FFFF_FFFF, 1'b1);
      rdc(3, 7, 40'h01_0000_0000, 1'b0);
      // Counters of an idle port stay untouched.
      for (int i = 0; i < 8; i++)
         rdc(0, i, 40'h0, 1'b0);
      repeat (3) @(posedge core_clk);
      give_verdict();
   end
endmodule : tb
